// ===== logic/fsl_pkg.sv
// Purpose: constants and types of the fault supervisor latch
// Assumes: 125 MHz clock, 16-bit registers at byte address 4*index
// Notes: deglitch minimums round up to whole cycles
`default_nettype none
package fsl_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int OTS_DGL_NS = 2000;
    localparam int UVOV_DGL_NS = 3500;
    localparam int CP_DGL_NS = 4000;
    localparam int OTS_DGL_CYC = (OTS_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UVOV_DGL_CYC = (UVOV_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CP_DGL_CYC = (CP_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AR_PERIOD_MS = 64;
    localparam int AR_PERIOD_CYC = AR_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int DGL_W = 10;
    localparam int DW = 16;
    localparam int AW = 8;
    // register indexes, byte address is four times the index
    localparam logic [5:0] REG_QUICK_STATUS = 6'h01;
    localparam logic [5:0] REG_CH_FIRST = 6'h02;
    localparam logic [5:0] REG_DEV_STATUS = 6'h07;
    localparam logic [5:0] REG_OUT_CTRL = 6'h08;
    localparam logic [5:0] REG_IRQ_STATUS = 6'h09;
    localparam logic [5:0] REG_IRQ_MASK = 6'h0a;
    // field positions
    localparam int CH_ON_BIT = 0;
    localparam int CH_OTS_BIT = 0;
    localparam int QS_CPF_BIT = 8;
    localparam int DS_UVF_BIT = 0;
    localparam int DS_OVF_BIT = 1;
    localparam int DSF_BIT = 15;
    localparam int IRQ_UV_BIT = 8;
    localparam int IRQ_OV_BIT = 9;
    localparam int IRQ_CP_BIT = 10;
    localparam logic [DW-1:0] IRQ_MASK_RST = 16'h0000;
    localparam logic [DW-1:0] RDATA_RST = 16'h0000;
    typedef struct packed {
        logic uv;
        logic ov;
        logic cp_bad;
    } fsl_supply_s;
endpackage
`default_nettype wire

// ===== logic/fsl_fault_supervisor.sv
// Purpose: deglitch, shutdown, latched flags and restart of supply and thermal faults
// Assumes: inputs synchronous to clk_i; raw fault inputs high while condition present
// Notes: channel control writes and channel status reads share indexes 2..6
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fsl_fault_supervisor
    import fsl_pkg::*;
#(
    parameter int N_CH = 5,
    parameter int AR_CYC = AR_PERIOD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [DW-1:0] rdata_o,
    input wire logic [N_CH-1:0] ot_raw_i,
    input wire fsl_supply_s supply_i,
    input wire logic fail_mode_i,
    input wire logic mode_trans_i,
    output logic [N_CH-1:0] out_en_o,
    output logic [N_CH-1:0] inrush_start_o,
    output logic irq_o
);
    localparam int NF = N_CH + 3;
    localparam int UV = N_CH;
    localparam int OV = N_CH + 1;
    localparam int CP = N_CH + 2;
    localparam int ARW = $clog2(AR_CYC + 1);

    function automatic logic reg_hit(input logic [AW-1:0] a, input logic [5:0] idx);
        return (a[1:0] == 2'h0) && (a[7:2] == idx);
    endfunction

    function automatic logic [DGL_W-1:0] dgl_limit(input int g);
        if (g < N_CH) begin
            return DGL_W'(OTS_DGL_CYC - 1);
        end else if (g == CP) begin
            return DGL_W'(CP_DGL_CYC - 1);
        end
        return DGL_W'(UVOV_DGL_CYC - 1);
    endfunction

    // ****************************************
    // deglitch filters
    // ****************************************
    logic [NF-1:0] raw;
    logic [NF-1:0] flt_q;
    logic [NF-1:0] flt_set;
    logic [DGL_W-1:0] cnt_q [NF];

    assign raw = {supply_i.cp_bad, supply_i.ov, supply_i.uv, ot_raw_i};

    for (genvar g = 0; g < NF; g++) begin : g_dgl
        assign flt_set[g] = raw[g] && (cnt_q[g] == dgl_limit(g)) && !flt_q[g];
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                cnt_q[g] <= '0;
                flt_q[g] <= 1'b0;
            end else if (!raw[g]) begin
                // any drop restarts the count; glitches never latch
                cnt_q[g] <= '0;
                flt_q[g] <= 1'b0;
            end else if (cnt_q[g] == dgl_limit(g)) begin
                flt_q[g] <= 1'b1;
            end else begin
                cnt_q[g] <= cnt_q[g] + 1'b1;
            end
        end
    end

    // ****************************************
    // register decode
    // ****************************************
    logic [N_CH-1:0] rd_ch;
    logic [N_CH-1:0] wr_on;
    logic [N_CH-1:0] on_cmd_q;
    logic rd_quick;
    logic rd_dev;

    assign rd_quick = re_i && reg_hit(addr_i, REG_QUICK_STATUS);
    assign rd_dev = re_i && reg_hit(addr_i, REG_DEV_STATUS);

    for (genvar i = 0; i < N_CH; i++) begin : g_dec
        logic hit_ch;
        logic hit_out;
        assign hit_ch = reg_hit(addr_i, 6'(REG_CH_FIRST + 6'(i)));
        assign hit_out = reg_hit(addr_i, REG_OUT_CTRL);
        assign rd_ch[i] = re_i && hit_ch;
        assign wr_on[i] = we_i && ((hit_ch && wdata_i[CH_ON_BIT]) || (hit_out && wdata_i[i]));
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                on_cmd_q[i] <= 1'b0;
            end else if (we_i && hit_ch) begin
                on_cmd_q[i] <= wdata_i[CH_ON_BIT];
            end else if (we_i && hit_out) begin
                on_cmd_q[i] <= wdata_i[i];
            end
        end
    end

    // ****************************************
    // autorestart timer, fail mode only
    // ****************************************
    logic [N_CH-1:0] uv_blk_q;
    logic [ARW-1:0] ar_cnt_q;
    logic ar_fire;

    assign ar_fire = fail_mode_i && (|uv_blk_q) && (ar_cnt_q == ARW'(AR_CYC - 1));

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ar_cnt_q <= '0;
        end else if (!fail_mode_i || !(|uv_blk_q) || ar_fire) begin
            ar_cnt_q <= '0;
        end else begin
            ar_cnt_q <= ar_cnt_q + 1'b1;
        end
    end

    // ****************************************
    // shutdown latches and outputs
    // ****************************************
    logic [N_CH-1:0] ot_blk_q;
    logic [N_CH-1:0] out_d;
    logic [N_CH-1:0] out_q;
    logic [N_CH-1:0] inrush_q;

    for (genvar i = 0; i < N_CH; i++) begin : g_out
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                ot_blk_q[i] <= 1'b0;
            end else if (flt_set[i]) begin
                ot_blk_q[i] <= 1'b1;
            end else if (!fail_mode_i && wr_on[i] && !ot_raw_i[i]) begin
                ot_blk_q[i] <= 1'b0;
            end else if (mode_trans_i && !ot_raw_i[i]) begin
                ot_blk_q[i] <= 1'b0;
            end
        end
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                uv_blk_q[i] <= 1'b0;
            end else if (flt_set[UV]) begin
                uv_blk_q[i] <= 1'b1;
            end else if (!fail_mode_i && wr_on[i] && !supply_i.uv) begin
                uv_blk_q[i] <= 1'b0;
            end else if (ar_fire && !supply_i.uv) begin
                uv_blk_q[i] <= 1'b0;
            end
        end
    end

    // raw pump state gates until the first good sample; the filter is too slow at power-up
    logic cp_ok_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cp_ok_q <= 1'b0;
        end else if (!supply_i.cp_bad) begin
            cp_ok_q <= 1'b1;
        end
    end

    // pump and overvoltage gate without latching, so a held command resumes
    assign out_d = on_cmd_q & ~ot_blk_q & ~uv_blk_q & ~flt_set[N_CH-1:0]
                 & {N_CH{cp_ok_q && !flt_set[UV] && !flt_q[OV] && !flt_q[CP]
                 && !flt_set[CP]}};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_q <= '0;
            inrush_q <= '0;
        end else begin
            out_q <= out_d;
            inrush_q <= out_d & ~out_q;
        end
    end

    // ****************************************
    // latched diagnosis flags
    // ****************************************
    logic [N_CH-1:0] ots_flag_q;
    logic uvf_q;
    logic ovf_q;
    logic cpf_q;
    logic device_fault_summary;

    assign device_fault_summary = uvf_q || ovf_q || cpf_q;

    for (genvar i = 0; i < N_CH; i++) begin : g_flag
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                ots_flag_q[i] <= 1'b0;
            end else if (flt_set[i]) begin
                ots_flag_q[i] <= 1'b1;
            end else if (rd_ch[i] && !ot_raw_i[i]) begin
                ots_flag_q[i] <= 1'b0;
            end
        end
    end

    // set beats a clearing read in the same cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            uvf_q <= 1'b0;
            ovf_q <= 1'b0;
            cpf_q <= 1'b0;
        end else begin
            uvf_q <= flt_set[UV] || (uvf_q && !(rd_dev && !supply_i.uv));
            ovf_q <= flt_set[OV] || (ovf_q && !(rd_dev && !supply_i.ov));
            cpf_q <= flt_set[CP] || (cpf_q && !(rd_quick && !supply_i.cp_bad));
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    logic [DW-1:0] irq_ev;
    logic [DW-1:0] irq_st_q;
    logic [DW-1:0] irq_mask_q;
    logic irq_q;

    always_comb begin
        irq_ev = '0;
        irq_ev[N_CH-1:0] = flt_set[N_CH-1:0];
        irq_ev[IRQ_UV_BIT] = flt_set[UV];
        irq_ev[IRQ_OV_BIT] = flt_set[OV];
        irq_ev[IRQ_CP_BIT] = flt_set[CP];
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_st_q <= '0;
            irq_mask_q <= IRQ_MASK_RST;
            irq_q <= 1'b0;
        end else begin
            if (we_i && reg_hit(addr_i, REG_IRQ_STATUS)) begin
                irq_st_q <= (irq_st_q & ~wdata_i) | irq_ev;
            end else begin
                irq_st_q <= irq_st_q | irq_ev;
            end
            if (we_i && reg_hit(addr_i, REG_IRQ_MASK)) begin
                irq_mask_q <= wdata_i;
            end
            irq_q <= |(irq_st_q & irq_mask_q);
        end
    end

    // ****************************************
    // read data, valid only the cycle after the strobe
    // ****************************************
    logic [DW-1:0] rd_d;
    logic [DW-1:0] rdata_q;

    always_comb begin
        rd_d = '0;
        if (rd_quick) begin
            rd_d[N_CH-1:0] = ots_flag_q;
            rd_d[QS_CPF_BIT] = cpf_q;
            rd_d[DSF_BIT] = device_fault_summary;
        end else if (rd_dev) begin
            rd_d[DS_UVF_BIT] = uvf_q;
            rd_d[DS_OVF_BIT] = ovf_q;
            rd_d[DSF_BIT] = device_fault_summary;
        end else if (re_i && reg_hit(addr_i, REG_OUT_CTRL)) begin
            rd_d[N_CH-1:0] = on_cmd_q;
        end else if (re_i && reg_hit(addr_i, REG_IRQ_STATUS)) begin
            rd_d = irq_st_q;
        end else if (re_i && reg_hit(addr_i, REG_IRQ_MASK)) begin
            rd_d = irq_mask_q;
        end
        for (int i = 0; i < N_CH; i++) begin
            if (rd_ch[i]) begin
                rd_d[CH_OTS_BIT] = ots_flag_q[i];
                rd_d[DSF_BIT] = device_fault_summary;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= RDATA_RST;
        end else begin
            rdata_q <= rd_d;
        end
    end

    assign rdata_o = rdata_q;
    assign out_en_o = out_q;
    assign inrush_start_o = inrush_q;
    assign irq_o = irq_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_ar_quiet;
        !ar_fire [*8];
    endsequence

    a_ots_out_off: assert property (flt_set[0] |=> !out_en_o[0] && ot_blk_q[0])
        else $error("channel stayed on after overtemp shutdown");
    a_ots_flagged: assert property (flt_set[0] |=> ots_flag_q[0] && irq_st_q[0])
        else $error("overtemp shutdown not flagged");
    a_ots_restart: assert property ($fell(ot_blk_q[0]) |-> $past(wr_on[0] || mode_trans_i))
        else $error("overtemp block released without command");
    a_ots_flag_clr: assert property ($fell(ots_flag_q[0]) |-> $past(rd_ch[0] && !ot_raw_i[0]))
        else $error("overtemp flag cleared without read");
    a_fail_hold: assert property (fail_mode_i && ot_blk_q[0] && !mode_trans_i |=> ot_blk_q[0])
        else $error("fail mode overtemp restart without transition");
    a_uv_flags: assert property (flt_set[UV] |=> uvf_q && device_fault_summary && !(|out_en_o))
        else $error("undervoltage not flagged");
    a_uv_restart: assert property ($fell(uv_blk_q[0]) |-> $past(!supply_i.uv && (ar_fire || wr_on[0])))
        else $error("undervoltage restart without cause");
    a_supply_clr: assert property ($fell(uvf_q) |-> $past(rd_dev && !supply_i.uv))
        else $error("undervoltage flag cleared without read");
    a_fail_uv: assert property (fail_mode_i && uv_blk_q[0] && !ar_fire |=> uv_blk_q[0])
        else $error("fail mode undervoltage restart by command");
    a_ar_spacing: assert property (ar_fire |=> s_ar_quiet)
        else $error("autorestart attempts too close");
    a_ov_flags: assert property (flt_set[OV] |=> ovf_q ##1 !(|out_en_o))
        else $error("overvoltage not flagged");
    a_uv_dgl: assert property ($rose(flt_q[UV]) |-> $past(supply_i.uv, UVOV_DGL_CYC))
        else $error("undervoltage acted on before deglitch");
    a_cp_off: assert property (flt_q[CP] |=> out_en_o == '0)
        else $error("outputs on during pump fault");
    a_pump_settle: assert property (!cp_ok_q |=> out_en_o == '0)
        else $error("output on before pump settled");
    a_cp_flag: assert property (flt_set[CP] |=> cpf_q && irq_st_q[IRQ_CP_BIT])
        else $error("pump fault not flagged");
    a_inrush: assert property ($rose(out_en_o[0]) |-> inrush_start_o[0])
        else $error("turn-on without inrush start");
    a_cpf_clr: assert property ($fell(cpf_q) |-> $past(rd_quick && !supply_i.cp_bad))
        else $error("pump flag cleared without read");
    a_dgl_reset: assert property (!raw[UV] |=> !flt_q[UV] && cnt_q[UV] == '0)
        else $error("deglitch not restarted");
endmodule
`default_nettype wire

// ===== test/fsl_mcu_model.sv
// Purpose: controller model driving the register port of the supervisor
// Assumes: strobes one cycle long, read data valid only the cycle after
// Notes: tasks are called by the bench; signals move only by NBA at a rising edge
`timescale 1ns/1ps
`default_nettype none
module fsl_mcu_model
    import fsl_pkg::*;
(
    input wire logic clk_i,
    output logic [AW-1:0] addr_o,
    output logic [DW-1:0] wdata_o,
    output logic we_o,
    output logic re_o,
    input wire logic [DW-1:0] rdata_i
);
    // ****************************************
    // bus cycles
    // ****************************************
    initial begin
        addr_o = 8'h00;
        wdata_o = 16'h0000;
        we_o = 1'b0;
        re_o = 1'b0;
    end
    // on-bit writes are how the controller restarts a channel
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        we_o <= 1'b1;
        @(posedge clk_i);
        we_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    // status reads are what release latched flags
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk_i);
        addr_o <= a;
        re_o <= 1'b1;
        @(posedge clk_i);
        re_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
// Purpose: self-checking bench of the fault supervisor latch
// Assumes: autorestart shortened to 20 cycles
// Notes: only channels 0 and 1 are switched on
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fsl_pkg::*;
    localparam int AR = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic we;
    logic re;
    logic irq;
    logic fail_mode = 1'b0;
    logic mode_trans = 1'b0;
    logic [4:0] ot_raw = 5'h00;
    logic [4:0] out_en;
    logic [4:0] inrush;
    fsl_supply_s supply = 3'b000;
    int error_cnt = 0;
    int compares = 0;
    always #4 clk_i = ~clk_i;
    fsl_mcu_model mcu (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .we_o(we),
        .re_o(re), .rdata_i(rdata));
    fsl_fault_supervisor #(.N_CH(5), .AR_CYC(AR)) fsl_fault_supervisor_inst (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .we_i(we),
        .re_i(re), .rdata_o(rdata), .ot_raw_i(ot_raw), .supply_i(supply),
        .fail_mode_i(fail_mode), .mode_trans_i(mode_trans), .out_en_o(out_en),
        .inrush_start_o(inrush), .irq_o(irq));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic rdchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        logic [DW-1:0] d;
        mcu.rd(a, d);
        chk(d, exp);
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_ots();
        mcu.wr(8'h20, 16'h0003);
        @(posedge clk_i);
        ot_raw <= 5'h01;
        cyc(OTS_DGL_CYC - 2);
        @(posedge clk_i);
        ot_raw <= 5'h00;
        cyc(4);
        chk(DW'(out_en), 16'h0003);
        @(posedge clk_i);
        ot_raw <= 5'h01;
        cyc(OTS_DGL_CYC + 3);
        chk(DW'(out_en), 16'h0002);
        rdchk(8'h04, 16'h0001);
        rdchk(8'h08, 16'h0001);
        @(posedge clk_i);
        ot_raw <= 5'h00;
        cyc(3);
        chk(DW'(out_en), 16'h0002);
        rdchk(8'h08, 16'h0001);
        rdchk(8'h08, 16'h0000);
        rdchk(8'h04, 16'h0000);
        mcu.wr(8'h20, 16'h0003);
        cyc(2);
        chk(DW'(out_en), 16'h0003);
        mcu.wr(8'h24, 16'hffff);
    endtask
    task automatic t_supply();
        for (int i = 0; i < 2; i++) begin
            mcu.wr(8'h28, 16'h0100 << i);
            @(posedge clk_i);
            supply <= (i == 0) ? 3'b100 : 3'b010;
            cyc(UVOV_DGL_CYC - 4);
            chk(DW'(out_en), 16'h0003);
            cyc(8);
            chk(DW'(out_en), 16'h0000);
            chk(DW'(irq), 16'h0001);
            rdchk(8'h1c, 16'h8000 | (16'h0001 << i));
            @(posedge clk_i);
            supply <= 3'b000;
            cyc(3);
            chk(DW'(out_en), (i == 0) ? 16'h0000 : 16'h0003);
            rdchk(8'h1c, 16'h8000 | (16'h0001 << i));
            rdchk(8'h1c, 16'h0000);
            mcu.wr(8'h20, 16'h0003);
            mcu.wr(8'h24, 16'hffff);
            cyc(2);
            chk(DW'(out_en), 16'h0003);
            chk(DW'(irq), 16'h0000);
        end
    endtask
    task automatic t_pump();
        int seen;
        seen = 0;
        mcu.wr(8'h28, 16'h0000);
        mcu.wr(8'h0c, 16'h0000);
        @(posedge clk_i);
        supply <= 3'b001;
        cyc(CP_DGL_CYC + 3);
        chk(DW'(out_en), 16'h0000);
        chk(DW'(irq), 16'h0000);
        rdchk(8'h24, 16'h0400);
        rdchk(8'h04, 16'h8100);
        rdchk(8'h1c, 16'h8000);
        mcu.wr(8'h0c, 16'h0001);
        @(posedge clk_i);
        supply <= 3'b000;
        for (int k = 0; k < 10; k++) begin
            cyc(1);
            if (inrush[1] === 1'b1) seen++;
        end
        chk(DW'(seen), 16'h0001);
        chk(DW'(out_en), 16'h0003);
        rdchk(8'h04, 16'h8100);
        rdchk(8'h04, 16'h0000);
        mcu.wr(8'h24, 16'hffff);
        rdchk(8'h24, 16'h0000);
    endtask
    task automatic t_fail();
        int n;
        @(posedge clk_i);
        fail_mode <= 1'b1;
        ot_raw <= 5'h01;
        cyc(OTS_DGL_CYC + 3);
        @(posedge clk_i);
        ot_raw <= 5'h00;
        mcu.wr(8'h20, 16'h0003);
        cyc(AR + 10);
        chk(DW'(out_en), 16'h0002);
        @(posedge clk_i);
        mode_trans <= 1'b1;
        @(posedge clk_i);
        mode_trans <= 1'b0;
        cyc(2);
        chk(DW'(out_en), 16'h0003);
        rdchk(8'h08, 16'h0001);
        @(posedge clk_i);
        supply <= 3'b100;
        cyc(UVOV_DGL_CYC + 3);
        chk(DW'(out_en), 16'h0000);
        @(posedge clk_i);
        supply <= 3'b000;
        n = 0;
        while (out_en !== 5'h03 && n < 3 * AR) begin
            cyc(1);
            n++;
        end
        chk(DW'(n >= AR - 6 && n <= AR + 3), 16'h0001);
        rdchk(8'h1c, 16'h8001);
        mcu.wr(8'h24, 16'hffff);
        fail_mode <= 1'b0;
    endtask
    task automatic t_map();
        rdchk(8'h05, 16'h0000);
        rdchk(8'h3c, 16'h0000);
        mcu.wr(8'h21, 16'h0000);
        cyc(2);
        chk(DW'(out_en), 16'h0003);
    endtask
    task automatic t_powerup();
        @(posedge clk_i);
        rst_i <= 1'b1;
        supply <= 3'b001;
        cyc(4);
        @(posedge clk_i);
        rst_i <= 1'b0;
        mcu.wr(8'h20, 16'h0003);
        cyc(20);
        chk(DW'(out_en), 16'h0000);
        @(posedge clk_i);
        supply <= 3'b000;
        cyc(3);
        chk(DW'(out_en), 16'h0003);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        cyc(1);
        chk(DW'(out_en), 16'h0000);
        t_ots();
        t_supply();
        t_pump();
        t_fail();
        t_map();
        t_powerup();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        stop_test();
    end
endmodule
`default_nettype wire
